//--- pinmux_pkg.sv
// Shared constants and types for the pin multiplexer and its board partner
package pinmux_pkg;

	// ========================================================
	// Widths
	localparam int DATA_W = 16;
	localparam int ADDR_W = 4;
	localparam int GP_N   = 16;
	localparam int CTL_N  = 4;

	// ========================================================
	// Register indices on the plain register port
	localparam logic [3:0] REG_GPIO_DIR = 4'h0;
	localparam logic [3:0] REG_GPIO_OUT = 4'h1;
	localparam logic [3:0] REG_GPIO_IN  = 4'h2;
	localparam logic [3:0] REG_FUNC     = 4'h3;
	localparam logic [3:0] REG_IRQ_EN   = 4'h4;
	localparam logic [3:0] REG_POL      = 4'h5;
	localparam logic [3:0] REG_STAT     = 4'h6;
	localparam logic [3:0] REG_MASK     = 4'h7;
	localparam logic [3:0] REG_STRAP    = 4'h8;
	localparam logic [3:0] REG_HOST     = 4'h9;

	// ========================================================
	// Reset values
	localparam logic [15:0] GPIO_DIR_RST = 16'h0000;
	localparam logic [15:0] GPIO_OUT_RST = 16'h0000;
	localparam logic [5:0]  FUNC_RST     = 6'h00;
	localparam logic [3:0]  NIBBLE_RST   = 4'h0;

	// ========================================================
	// Function select fields
	localparam int FUNC_GP1    = 0;
	localparam int FUNC_GP2    = 1;
	localparam int FUNC_GP8    = 2;
	localparam int FUNC_GP15_9 = 3;
	localparam int FUNC_GP0_LO = 4;

	// Interrupt enable register holds its bits at positions 7 to 4
	localparam int IEN_LO = 4;

	// Strap status fields
	localparam int STRAP_PCI    = 0;
	localparam int STRAP_SER2   = 1;
	localparam int STRAP_HPORT  = 2;
	localparam int STRAP_SER2EN = 3;
	localparam int STRAP_EEPROM = 4;

	// ========================================================
	// Pin groups
	localparam int EXT_LO = 4;
	localparam int EXT_N  = 4;
	localparam int PCI_LO = 9;
	localparam int PCI_N  = 7;

	// Control pin order on the host control group
	localparam int CTL_HI = 3;
	localparam int CTL_LO = 2;
	localparam int CTL_HW = 1;
	localparam int CTL_RW = 0;

	// ========================================================
	// Clock divider ratios
	localparam int CLK_DIV4 = 4;
	localparam int CLK_DIV6 = 6;

	// ========================================================
	// Types
	typedef enum logic [1:0] {GP0_IN, GP0_OUT, GP0_IRQ} gp0_mode_t;
	typedef enum logic [1:0] {ACC_IDLE, ACC_FIRST, ACC_SECOND} acc_state_t;

endpackage : pinmux_pkg

//--- pin_if.sv
// Pin-level carrier between the processor end and the board end
`timescale 1ns/100ps
`default_nettype none
interface pin_if;
	import pinmux_pkg::*;

	// ========================================================
	// Drivers of each side
	logic [GP_N-1:0]  dev_gp_o;
	logic [GP_N-1:0]  dev_gp_oe;
	logic [GP_N-1:0]  brd_gp_o;
	logic [GP_N-1:0]  brd_gp_oe;
	logic             dev_frame_o;
	logic             dev_frame_oe;
	logic             brd_frame_o;
	logic             brd_frame_oe;
	logic [CTL_N-1:0] dev_ctl_o;
	logic [CTL_N-1:0] dev_ctl_oe;
	logic [CTL_N-1:0] brd_ctl_o;
	logic [CTL_N-1:0] brd_ctl_oe;
	logic             pci_en;
	logic             serial2_select_strap;

	// ========================================================
	// Resolved wire levels, undriven pins pulled low
	logic [GP_N-1:0]  gp_lvl;
	logic             frame_lvl;
	logic [CTL_N-1:0] ctl_lvl;

	assign gp_lvl    = (dev_gp_o & dev_gp_oe) | (brd_gp_o & brd_gp_oe);
	assign frame_lvl = (dev_frame_o & dev_frame_oe)
		| (brd_frame_o & brd_frame_oe);
	assign ctl_lvl   = (dev_ctl_o & dev_ctl_oe) | (brd_ctl_o & brd_ctl_oe);

	modport dev (
		output dev_gp_o, dev_gp_oe, dev_frame_o, dev_frame_oe,
		output dev_ctl_o, dev_ctl_oe,
		input  gp_lvl, frame_lvl, ctl_lvl, pci_en, serial2_select_strap
	);
	modport brd (
		output brd_gp_o, brd_gp_oe, brd_frame_o, brd_frame_oe,
		output brd_ctl_o, brd_ctl_oe, pci_en, serial2_select_strap,
		input  gp_lvl, frame_lvl, ctl_lvl
	);
endinterface : pin_if
`default_nettype wire

//--- clk_div.sv
// Free-running even-ratio clock divider with a registered output
`timescale 1ns/100ps
`default_nettype none
module clk_div
	import pinmux_pkg::*;
#(
	parameter int DIV = CLK_DIV4
) (
	// Clock and reset
	input  wire logic CORE_CLK,
	input  wire logic RST_N,
	// Divided clock
	output var  logic CLK_O
);
	localparam logic [2:0] HALF_LAST = 3'(DIV / 2 - 1);

	logic [2:0] cnt_r;
	logic       clk_r;
	wire        wrap = (cnt_r == HALF_LAST);

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			cnt_r <= 3'h0;
			clk_r <= 1'b0;
		end else begin
			cnt_r <= wrap ? 3'h0 : 3'(cnt_r + 3'h1);
			clk_r <= wrap ? ~clk_r : clk_r;
		end
	end

	assign CLK_O = clk_r;
endmodule : clk_div
`default_nettype wire

//--- pinmux_dev.sv
// Processor end: pin multiplexer, GPIO and edge-triggered external interrupts
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module pinmux_dev
	import pinmux_pkg::*;
(
	// Clock and reset
	input  wire logic              CORE_CLK,
	input  wire logic              RST_N,
	// Pins
	pin_if.dev                     PINS,
	// Register port
	input  wire logic [ADDR_W-1:0] REG_ADDR,
	input  wire logic [DATA_W-1:0] REG_WDATA,
	input  wire logic              REG_WR,
	input  wire logic              REG_RD,
	output var  logic [DATA_W-1:0] REG_RDATA,
	output var  logic              IRQ,
	// PCI engine side
	input  wire logic [PCI_N-1:0]  PCI_GP_O,
	input  wire logic [PCI_N-1:0]  PCI_GP_OE,
	output var  logic [PCI_N-1:0]  PCI_GP_I,
	input  wire logic              PCI_FRAME_O,
	input  wire logic              PCI_FRAME_OE,
	output var  logic              PCI_FRAME_I,
	input  wire logic [CTL_N-1:0]  PCI_CTL_O,
	input  wire logic [CTL_N-1:0]  PCI_CTL_OE,
	output var  logic [CTL_N-1:0]  PCI_CTL_I,
	// Host port engine side
	output var  logic [CTL_N-1:0]  HOST_CTL,
	output var  logic              SERIAL2_CLK,
	// Peripheral enables
	output var  logic              HOST_PORT_EN,
	output var  logic              SERIAL2_EN,
	output var  logic              PCI_EEPROM_EN
);
	// ========================================================
	// Helpers
	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic strobe, input logic [ADDR_W-1:0] target);
		return strobe & (a == target);
	endfunction : hit

	function automatic logic edge_hit(input logic prev, input logic cur,
		input logic falling);
		return falling ? (prev & ~cur) : (~prev & cur);
	endfunction : edge_hit

	// ========================================================
	// State
	logic [15:0]       dir_r;
	logic [15:0]       out_r;
	logic [5:0]        func_r;
	logic [3:0]        ien_r;
	logic [3:0]        pol_r;
	logic [3:0]        stat_r;
	logic [3:0]        mask_r;
	logic              hirq_r;
	logic [1:0]        strap_r;
	logic [2:0]        en_r;
	logic [EXT_N-1:0]  ext_s1_r;
	logic [EXT_N-1:0]  ext_s2_r;
	logic [EXT_N-1:0]  ext_prev_r;
	logic [15:0]       gp_in_r;
	logic [15:0]       gp_o_r;
	logic [15:0]       gp_oe_r;
	logic [15:0]       gp_o_nxt;
	logic [15:0]       gp_oe_nxt;
	logic              frame_o_r;
	logic              frame_oe_r;
	logic [CTL_N-1:0]  ctl_oe_r;
	logic [CTL_N-1:0]  ctl_o_r;
	logic [DATA_W-1:0] rdata_nxt;
	logic              irq_r;
	logic [PCI_N-1:0]  pci_gp_i_r;
	logic              pci_frame_i_r;
	logic [CTL_N-1:0]  pci_ctl_i_r;
	logic [CTL_N-1:0]  host_ctl_r;
	logic              ser2_clk_r;
	logic              div4_clk;
	logic              div6_clk;

	// ========================================================
	// Decode
	wire              pci_mode  = strap_r[0];
	wire              ser2_mode = strap_r[1];
	wire              host_en   = en_r[0];
	wire              ser2_en   = en_r[1];
	wire              eeprom_en = en_r[2];
	wire              rd_stat   = hit(REG_ADDR, REG_RD, REG_STAT);
	wire [EXT_N-1:0]  ext_evt;
	wire [3:0]        stat_nxt;
	wire              irq_nxt   = |(stat_nxt & mask_r);
	wire gp0_mode_t   gp0_mode  = gp0_mode_t'(func_r[FUNC_GP0_LO +: 2]);
	wire [4:0]        strap_vec = {eeprom_en, ser2_en, host_en,
		ser2_mode, pci_mode};

	// Second stage only feeds the edge compare, never the first stage
	genvar gi;
	generate
		for (gi = 0; gi < EXT_N; gi++) begin : g_edge
			assign ext_evt[gi] = ien_r[gi]
				& edge_hit(ext_prev_r[gi], ext_s2_r[gi], pol_r[gi]);
		end
	endgenerate

	// New events win over a clearing read in the same cycle
	assign stat_nxt = (rd_stat ? 4'h0 : stat_r) | ext_evt;

	// ========================================================
	// Clock outputs
	clk_div #(.DIV(CLK_DIV4)) u_div4 (
		.CORE_CLK (CORE_CLK),
		.RST_N    (RST_N),
		.CLK_O    (div4_clk)
	);
	clk_div #(.DIV(CLK_DIV6)) u_div6 (
		.CORE_CLK (CORE_CLK),
		.RST_N    (RST_N),
		.CLK_O    (div6_clk)
	);

	// ========================================================
	// Pin selection
	always_comb begin
		gp_o_nxt  = out_r;
		gp_oe_nxt = dir_r;
		case (gp0_mode)
			GP0_IN: begin
				gp_oe_nxt[0] = 1'b0;
			end
			GP0_OUT: begin
				gp_oe_nxt[0] = 1'b1;
			end
			GP0_IRQ: begin
				gp_oe_nxt[0] = 1'b1;
				gp_o_nxt[0]  = irq_nxt;
			end
			default: begin
				gp_oe_nxt[0] = 1'b0;
			end
		endcase
		if (!func_r[FUNC_GP1]) begin
			gp_o_nxt[1]  = div4_clk;
			gp_oe_nxt[1] = 1'b1;
		end
		if (!func_r[FUNC_GP2]) begin
			gp_o_nxt[2]  = div6_clk;
			gp_oe_nxt[2] = 1'b1;
		end
		// Interrupt inputs with their enable bit set are never driven, whatever the direction bit
		gp_oe_nxt[EXT_LO +: EXT_N] = dir_r[EXT_LO +: EXT_N] & ~ien_r;
		if (!func_r[FUNC_GP8]) begin
			gp_oe_nxt[8] = 1'b0;
		end
		if (pci_mode) begin
			gp_o_nxt[PCI_LO +: PCI_N]  = PCI_GP_O;
			gp_oe_nxt[PCI_LO +: PCI_N] = PCI_GP_OE;
		end else if (!func_r[FUNC_GP15_9]) begin
			gp_oe_nxt[PCI_LO +: PCI_N] = '0;
		end
	end

	// ========================================================
	// Register read mux, unmapped reads give zero
	always_comb begin
		rdata_nxt = '0;
		if (REG_RD) begin
			case (REG_ADDR)
				REG_GPIO_DIR: rdata_nxt = dir_r;
				REG_GPIO_OUT: rdata_nxt = out_r;
				REG_GPIO_IN:  rdata_nxt = gp_in_r;
				REG_FUNC:     rdata_nxt = {10'h000, func_r};
				REG_IRQ_EN:   rdata_nxt = {8'h00, ien_r, 4'h0};
				REG_POL:      rdata_nxt = {12'h000, pol_r};
				REG_STAT:     rdata_nxt = {12'h000, stat_r};
				REG_MASK:     rdata_nxt = {12'h000, mask_r};
				REG_STRAP:    rdata_nxt = {11'h000, strap_vec};
				REG_HOST:     rdata_nxt = {15'h0000, hirq_r};
				default:      rdata_nxt = '0;
			endcase
		end
	end

	// ========================================================
	// Software registers
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			dir_r   <= GPIO_DIR_RST;
			out_r   <= GPIO_OUT_RST;
			func_r  <= FUNC_RST;
			ien_r   <= NIBBLE_RST;
			pol_r   <= NIBBLE_RST;
			mask_r  <= NIBBLE_RST;
			hirq_r  <= 1'b0;
			// Straps are held by the board through reset
			strap_r <= {PINS.serial2_select_strap, PINS.pci_en};
			// Enables fixed with the straps, so the outputs come from flops
			en_r    <= {PINS.pci_en & ~PINS.serial2_select_strap,
				PINS.serial2_select_strap, ~PINS.pci_en};
		end else begin
			if (hit(REG_ADDR, REG_WR, REG_GPIO_DIR)) dir_r <= REG_WDATA;
			if (hit(REG_ADDR, REG_WR, REG_GPIO_OUT)) out_r <= REG_WDATA;
			if (hit(REG_ADDR, REG_WR, REG_FUNC)) func_r <= REG_WDATA[5:0];
			if (hit(REG_ADDR, REG_WR, REG_IRQ_EN))
				ien_r <= REG_WDATA[IEN_LO +: 4];
			if (hit(REG_ADDR, REG_WR, REG_POL)) pol_r <= REG_WDATA[3:0];
			if (hit(REG_ADDR, REG_WR, REG_MASK)) mask_r <= REG_WDATA[3:0];
			if (hit(REG_ADDR, REG_WR, REG_HOST)) hirq_r <= REG_WDATA[0];
		end
	end

	// ========================================================
	// Pin and status flops
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			ext_s1_r      <= '0;
			ext_s2_r      <= '0;
			ext_prev_r    <= '0;
			stat_r        <= '0;
			irq_r         <= 1'b0;
			gp_in_r       <= '0;
			gp_o_r        <= '0;
			gp_oe_r       <= '0;
			frame_o_r     <= 1'b0;
			frame_oe_r    <= 1'b0;
			ctl_o_r       <= '0;
			ctl_oe_r      <= '0;
			REG_RDATA     <= '0;
			pci_gp_i_r    <= '0;
			pci_frame_i_r <= 1'b0;
			pci_ctl_i_r   <= '0;
			host_ctl_r    <= '0;
			ser2_clk_r    <= 1'b0;
		end else begin
			ext_s1_r      <= PINS.gp_lvl[EXT_LO +: EXT_N];
			ext_s2_r      <= ext_s1_r;
			ext_prev_r    <= ext_s2_r;
			stat_r        <= stat_nxt;
			irq_r         <= irq_nxt;
			gp_in_r       <= PINS.gp_lvl;
			gp_o_r        <= gp_o_nxt;
			gp_oe_r       <= gp_oe_nxt;
			frame_o_r     <= pci_mode ? PCI_FRAME_O : hirq_r;
			frame_oe_r    <= pci_mode ? PCI_FRAME_OE : 1'b1;
			ctl_o_r       <= PCI_CTL_O;
			ctl_oe_r      <= pci_mode ? PCI_CTL_OE : '0;
			REG_RDATA     <= rdata_nxt;
			pci_gp_i_r    <= pci_mode ? PINS.gp_lvl[PCI_LO +: PCI_N] : '0;
			pci_frame_i_r <= pci_mode & PINS.frame_lvl;
			pci_ctl_i_r   <= pci_mode ? PINS.ctl_lvl : '0;
			host_ctl_r    <= pci_mode ? '0 : PINS.ctl_lvl;
			ser2_clk_r    <= ~func_r[FUNC_GP8] & PINS.gp_lvl[8];
		end
	end

	// ========================================================
	// Outputs
	assign PINS.dev_gp_o     = gp_o_r;
	assign PINS.dev_gp_oe    = gp_oe_r;
	assign PINS.dev_frame_o  = frame_o_r;
	assign PINS.dev_frame_oe = frame_oe_r;
	assign PINS.dev_ctl_o    = ctl_o_r;
	assign PINS.dev_ctl_oe   = ctl_oe_r;
	assign IRQ               = irq_r;
	assign PCI_GP_I          = pci_gp_i_r;
	assign PCI_FRAME_I       = pci_frame_i_r;
	assign PCI_CTL_I         = pci_ctl_i_r;
	assign HOST_CTL          = host_ctl_r;
	assign SERIAL2_CLK       = ser2_clk_r;
	assign HOST_PORT_EN      = host_en;
	assign SERIAL2_EN        = ser2_en;
	assign PCI_EEPROM_EN     = eeprom_en;
endmodule : pinmux_dev
`default_nettype wire

//--- pinmux_brd.sv
// Board end: straps, far-side GPIO drive and host control sequencing
`timescale 1ns/100ps
`default_nettype none
module pinmux_brd
	import pinmux_pkg::*;
(
	// Clock and reset
	input  wire logic             CORE_CLK,
	input  wire logic             RST_N,
	// Pins
	pin_if.brd                    PINS,
	// Straps
	input  wire logic             PCI_EN_STRAP,
	input  wire logic             SERIAL2_STRAP,
	input  wire logic             NARROW,
	// Far-side GPIO
	input  wire logic [GP_N-1:0]  GP_O,
	input  wire logic [GP_N-1:0]  GP_OE,
	output var  logic [GP_N-1:0]  GP_I,
	// Host access
	input  wire logic             ACC_REQ,
	input  wire logic [1:0]       ACC_SEL,
	input  wire logic             ACC_RW,
	output var  logic             ACC_BUSY,
	output var  logic             HOST_IRQ,
	// PCI side
	input  wire logic             PCI_FRAME_O,
	input  wire logic             PCI_FRAME_OE,
	input  wire logic [CTL_N-1:0] PCI_CTL_O,
	input  wire logic [CTL_N-1:0] PCI_CTL_OE
);
	acc_state_t       state_r;
	acc_state_t       state_nxt;
	logic             pci_r;
	logic             ser2_r;
	logic [GP_N-1:0]  gp_o_r;
	logic [GP_N-1:0]  gp_oe_r;
	logic [GP_N-1:0]  gp_i_r;
	logic [CTL_N-1:0] acc_r;
	logic [CTL_N-1:0] acc_nxt;
	logic [CTL_N-1:0] ctl_o_r;
	logic [CTL_N-1:0] ctl_oe_r;
	logic             frame_o_r;
	logic             frame_oe_r;
	logic             irq_r;

	// ========================================================
	// Access sequencer
	wire start = (state_r == ACC_IDLE) & ACC_REQ & ~pci_r;

	// Pins take the next select so value and enable rise together
	assign acc_nxt = start ? {ACC_SEL, 1'b0, ACC_RW}
		: (state_r == ACC_FIRST) ? (acc_r | 4'(1 << CTL_HW)) : acc_r;

	always_comb begin
		case (state_r)
			ACC_IDLE:   state_nxt = start ? ACC_FIRST : ACC_IDLE;
			// Narrow port needs a second halfword phase
			ACC_FIRST:  state_nxt = NARROW ? ACC_SECOND : ACC_IDLE;
			ACC_SECOND: state_nxt = ACC_IDLE;
			default:    state_nxt = ACC_IDLE;
		endcase
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			state_r <= ACC_IDLE;
			acc_r   <= '0;
			pci_r   <= PCI_EN_STRAP;
			ser2_r  <= SERIAL2_STRAP;
		end else begin
			state_r <= state_nxt;
			acc_r   <= acc_nxt;
		end
	end

	// ========================================================
	// Pin drive
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			gp_o_r     <= '0;
			gp_oe_r    <= '0;
			gp_i_r     <= '0;
			ctl_o_r    <= '0;
			ctl_oe_r   <= '0;
			frame_o_r  <= 1'b0;
			frame_oe_r <= 1'b0;
			irq_r      <= 1'b0;
		end else begin
			gp_o_r     <= GP_O;
			gp_oe_r    <= GP_OE;
			gp_i_r     <= PINS.gp_lvl;
			ctl_o_r    <= pci_r ? PCI_CTL_O : acc_nxt;
			ctl_oe_r   <= pci_r ? PCI_CTL_OE
				: {CTL_N{state_nxt != ACC_IDLE}};
			frame_o_r  <= PCI_FRAME_O;
			frame_oe_r <= pci_r & PCI_FRAME_OE;
			irq_r      <= ~pci_r & PINS.frame_lvl;
		end
	end

	assign PINS.pci_en               = pci_r;
	assign PINS.serial2_select_strap = ser2_r;
	assign PINS.brd_gp_o             = gp_o_r;
	assign PINS.brd_gp_oe            = gp_oe_r;
	assign PINS.brd_ctl_o            = ctl_o_r;
	assign PINS.brd_ctl_oe           = ctl_oe_r;
	assign PINS.brd_frame_o          = frame_o_r;
	assign PINS.brd_frame_oe         = frame_oe_r;
	assign GP_I                      = gp_i_r;
	assign ACC_BUSY                  = (state_r != ACC_IDLE);
	assign HOST_IRQ                  = irq_r;
endmodule : pinmux_brd
`default_nettype wire

//--- pinmux_asserts.sv
// Checker on the pin carrier between the processor end and the board end
`timescale 1ns/100ps
`default_nettype none
module pinmux_asserts
	import pinmux_pkg::*;
(
	// Clock and reset
	input wire logic             CORE_CLK,
	input wire logic             RST_N,
	// Carrier signals
	input wire logic [GP_N-1:0]  dev_gp_o,
	input wire logic [GP_N-1:0]  dev_gp_oe,
	input wire logic             dev_frame_oe,
	input wire logic [CTL_N-1:0] dev_ctl_oe,
	input wire logic [CTL_N-1:0] brd_ctl_o,
	input wire logic [CTL_N-1:0] brd_ctl_oe,
	input wire logic             brd_frame_oe,
	input wire logic             pci_en,
	input wire logic             serial2_select_strap
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	// ==========
	// Pin rules
	a_idle_reset: assert property ($rose(RST_N) |->
		(dev_gp_oe & 16'hFFF9) == 16'h0000) else $error("pin driven at reset");
	// Output disabled passes that cycle of the check, since GPIO may take the pin over
	a_div4_high: assert property ($rose(dev_gp_o[1]) && dev_gp_oe[1] |->
		(dev_gp_o[1] || !dev_gp_oe[1])[*2] ##1 (!dev_gp_o[1] || !dev_gp_oe[1]))
		else $error("clock by four has wrong half period");
	a_div6_high: assert property ($rose(dev_gp_o[2]) && dev_gp_oe[2] |->
		(dev_gp_o[2] || !dev_gp_oe[2])[*3] ##1 (!dev_gp_o[2] || !dev_gp_oe[2]))
		else $error("clock by six has wrong half period");
	a_host_irq_out: assert property (!pci_en && $past(RST_N) |-> dev_frame_oe)
		else $error("host interrupt pin not driven");
	a_brd_frame: assert property (!pci_en |-> !brd_frame_oe)
		else $error("board drives host interrupt pin");
	a_ctl_quiet: assert property (!pci_en |-> dev_ctl_oe == 4'h0)
		else $error("device drives host control pins");
	a_hw_order: assert property (!pci_en && $rose(|brd_ctl_oe) |->
		!brd_ctl_o[CTL_HW] ##1 (brd_ctl_oe == 4'h0 || brd_ctl_o[CTL_HW]))
		else $error("halfword order wrong");
	a_access_len: assert property (!pci_en && $rose(|brd_ctl_oe) |->
		##[1:2] brd_ctl_oe == 4'h0) else $error("access too long");
	a_ctl_hold: assert property (!pci_en && |brd_ctl_oe &&
		|$past(brd_ctl_oe) |-> (brd_ctl_o & 4'hD) == ($past(brd_ctl_o) & 4'hD))
		else $error("select or direction moved in access");
	a_strap_stable: assert property ($past(RST_N) |->
		$stable(pci_en) && $stable(serial2_select_strap))
		else $error("strap moved outside reset");
	c_narrow: cover property (brd_ctl_oe != 4'h0 && brd_ctl_o[CTL_HW]);
	c_pci: cover property (pci_en && dev_frame_oe);
	c_gp0: cover property ($rose(dev_gp_o[0]) && dev_gp_oe[0]);
endmodule : pinmux_asserts
`default_nettype wire

//--- gpio_pin_mux_ext_interrupts_tb_top.sv
// Self-checking bench joining the processor end and the board end
`timescale 1ns/100ps
`default_nettype none
module gpio_pin_mux_ext_interrupts_tb_top
	import pinmux_pkg::*;
;
	logic              core_clk, rst_n, reg_wr, reg_rd, irq, pfo, pfoe, pfi;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, reg_rdata;
	logic [PCI_N-1:0]  pgo, pgoe, pgi;
	logic [CTL_N-1:0]  pco, pcoe, pci_ctl_i, host_ctl;
	logic              s2clk, hp_en, s2_en, ee_en, pci_s, s2_s, narrow;
	logic [GP_N-1:0]   gp_o, gp_oe, gp_i;
	logic              acc_req, acc_rw, acc_busy, host_irq;
	logic [1:0]        acc_sel;
	int                errors, checked, seed, i, n1, n2, p, m;
	// Register model; unmapped places keep nothing
	int mdl[16];
	int msk[16] = '{16'hFFFF, 16'hFFFF, 0, 16'h003F, 16'h00F0, 16'h000F, 0,
		16'h000F, 0, 16'h0001, 0, 0, 0, 0, 0, 0};
	pin_if pins ();
	pinmux_dev pinmux_dev_i (.CORE_CLK(core_clk), .RST_N(rst_n),
		.PINS(pins.dev), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
		.REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .IRQ(irq),
		.PCI_GP_O(pgo), .PCI_GP_OE(pgoe), .PCI_GP_I(pgi), .PCI_FRAME_O(pfo),
		.PCI_FRAME_OE(pfoe), .PCI_FRAME_I(pfi), .PCI_CTL_O(pco),
		.PCI_CTL_OE(pcoe), .PCI_CTL_I(pci_ctl_i), .HOST_CTL(host_ctl),
		.SERIAL2_CLK(s2clk), .HOST_PORT_EN(hp_en), .SERIAL2_EN(s2_en),
		.PCI_EEPROM_EN(ee_en));
	pinmux_brd pinmux_brd_i (.CORE_CLK(core_clk), .RST_N(rst_n),
		.PINS(pins.brd), .PCI_EN_STRAP(pci_s), .SERIAL2_STRAP(s2_s),
		.NARROW(narrow), .GP_O(gp_o), .GP_OE(gp_oe), .GP_I(gp_i),
		.ACC_REQ(acc_req), .ACC_SEL(acc_sel), .ACC_RW(acc_rw),
		.ACC_BUSY(acc_busy), .HOST_IRQ(host_irq), .PCI_FRAME_O(1'b0),
		.PCI_FRAME_OE(1'b0), .PCI_CTL_O(4'h0), .PCI_CTL_OE(4'h0));
	pinmux_asserts pinmux_asserts_i (.CORE_CLK(core_clk), .RST_N(rst_n),
		.dev_gp_o(pins.dev_gp_o), .dev_gp_oe(pins.dev_gp_oe),
		.dev_frame_oe(pins.dev_frame_oe), .dev_ctl_oe(pins.dev_ctl_oe),
		.brd_ctl_o(pins.brd_ctl_o), .brd_ctl_oe(pins.brd_ctl_oe),
		.brd_frame_oe(pins.brd_frame_oe), .pci_en(pins.pci_en),
		.serial2_select_strap(pins.serial2_select_strap));
	// ==========
	// Tasks
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t: %h vs %h", $time, g, e);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc
	task automatic wr(input int a, input int v);
		@(posedge core_clk);
		reg_addr  <= 4'(a);
		reg_wdata <= 16'(v);
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		mdl[a] = v & msk[a];
	endtask : wr
	task automatic rd(input int a, input int e, input logic [15:0] k = 16'hFFFF);
		@(posedge core_clk);
		reg_addr <= 4'(a);
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata & k, 16'(e));
	endtask : rd
	task automatic rst(input logic pc, input logic s2);
		@(posedge core_clk);
		rst_n <= 1'b0;
		pci_s <= pc;
		s2_s  <= s2;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		foreach (mdl[k]) mdl[k] = 0;
		rd(REG_STRAP, {pc & !s2, s2, !pc, s2, pc});
		chk({hp_en, s2_en, ee_en}, {!pc, s2, pc & !s2});
	endtask : rst
	task automatic close_out;
		if (errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out
	// ==========
	// Clock, watchdog
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Run needs some 350 cycles; the bound only cuts a hang
	initial begin
		#200000;
		errors++;
		close_out;
	end
	// ==========
	// Scenarios
	initial begin
		{rst_n, reg_wr, reg_rd, pfo, pfoe, pci_s, s2_s, narrow} = 8'h00;
		{reg_addr, reg_wdata, pgo, pgoe, pco, pcoe} = 0;
		{acc_req, acc_rw, acc_sel, gp_o} = 0;
		errors = 0;
		checked = 0;
		seed = 68;
		gp_oe = 16'h01F8;
		rst(1'b0, 1'($random(seed)));
		for (i = 0; i < 16; i++)
			if (!(i inside {2, 6, 8})) rd(i, 0);
		p = pins.gp_lvl[2:1];
		repeat (24) begin
			cyc(1);
			n1 += int'(pins.gp_lvl[1] && !p[0]);
			n2 += int'(pins.gp_lvl[2] && !p[1]);
			p = pins.gp_lvl[2:1];
		end
		chk(n1, 6);
		chk(n2, 4);
		for (i = 3; i < 16; i++) begin
			if (i inside {6, 8}) continue;
			wr(i, $random(seed));
			rd(i, mdl[i]);
		end
		rst(1'b0, !s2_s);
		m = $random(seed);
		@(posedge core_clk);
		gp_o <= 16'(m) & 16'h0108;
		cyc(5);
		rd(REG_GPIO_IN, m & 16'h0108, 16'h0108);
		chk(s2clk, m[8]);
		@(posedge core_clk);
		gp_oe <= 16'h00F8;
		wr(REG_GPIO_DIR, 16'h0101);
		wr(REG_GPIO_OUT, m);
		wr(REG_FUNC, 16'h0017);
		cyc(4);
		chk(gp_i & 16'h0107, m & 16'h0101);
		chk(s2clk, 0);
		wr(REG_FUNC, 16'h0027);
		for (i = 0; i < 4; i++) begin
			p = $random(seed) & 1;
			m = $random(seed) & 16'h000F;
			wr(REG_POL, p << i);
			wr(REG_MASK, m);
			wr(REG_IRQ_EN, 16 << i);
			for (int e = 0; e < 2; e++) begin
				@(posedge core_clk);
				gp_o[i + 4] <= (e == 0);
				cyc(10);
				n1 = (p == e) ? (1 << i) : 0;
				chk(irq, (n1 & m) != 0);
				chk(gp_i[0], (n1 & m) != 0);
				rd(REG_STAT, n1);
				rd(REG_STAT, 0);
			end
		end
		wr(REG_IRQ_EN, 0);
		@(posedge core_clk);
		gp_o[4] <= 1'b1;
		cyc(10);
		rd(REG_STAT, 0);
		for (i = 0; i < 8; i++) begin
			m = $random(seed);
			@(posedge core_clk);
			narrow  <= m[3];
			acc_sel <= 2'(i);
			acc_rw  <= m[0];
			acc_req <= 1'b1;
			@(posedge core_clk);
			acc_req <= 1'b0;
			cyc(1);
			chk(host_ctl, {2'(i), 1'b0, m[0]});
			cyc(1);
			chk(host_ctl, m[3] ? {2'(i), 1'b1, m[0]} : 4'h0);
			cyc(2);
			chk(acc_busy, 0);
		end
		for (i = 1; i >= 0; i--) begin
			wr(REG_HOST, i);
			cyc(3);
			chk(host_irq, i[0]);
		end
		rst(1'b1, 1'($random(seed)));
		m = $random(seed);
		@(posedge core_clk);
		pgo  <= 7'(m);
		pgoe <= 7'h7F;
		pfo  <= m[8];
		pfoe <= 1'b1;
		pco  <= m[12:9];
		pcoe <= 4'hF;
		cyc(5);
		chk(gp_i[15:9], 7'(m));
		chk(pgi, 7'(m));
		chk({pfi, pci_ctl_i}, {m[8], m[12:9]});
		chk({host_ctl, host_irq}, 0);
		close_out;
	end
endmodule : gpio_pin_mux_ext_interrupts_tb_top
`default_nettype wire
